// ==== core/mxb_pkg.sv ====
// ==========================================================
// Shared constants of the multiplexed bus block
package mxb_pkg;

    // ======================================================
    // Widths
    localparam int unsigned ADDR_W = 16;
    localparam int unsigned BYTE_W = 8;

    // ======================================================
    // Bus cycle timing, in system clock cycles
    localparam int unsigned ADDR_CYCLES = 2;
    localparam int unsigned LATCH_PULSE_CYCLES = 1;
    localparam int unsigned DATA_CYCLES = 3;

    // ======================================================
    // Clock output rate select codes
    localparam logic [1:0] CLK_RATE_FULL = 2'h0;
    localparam logic [1:0] CLK_RATE_HALF = 2'h1;
    localparam logic [1:0] CLK_RATE_QUARTER = 2'h2;

    // ======================================================
    // Strobe pin function select
    localparam logic STROBE_IS_LATCH = 1'b0;
    localparam logic STROBE_IS_VALID = 1'b1;

    // ======================================================
    // Reset values
    localparam logic [ADDR_W-1:0] RST_WORD = 16'h0000;
    localparam logic [2:0] RST_DIV = 3'h0;

    // ======================================================
    // Bus sequencer states
    typedef enum logic [1:0] {
        MXB_IDLE = 2'b00,
        MXB_ADDR = 2'b01,
        MXB_DATA = 2'b10
    } mxb_state_t;

endpackage

// ==== core/mxb_clk_if.sv ====
`timescale 1ns/1ps
// ==========================================================
// Clock output generator link
interface mxb_clk_if;
    logic [1:0] rate_sel;
    logic enable;
    logic clk_out;

    modport gen (
        input rate_sel,
        input enable,
        output clk_out
    );

    modport user (
        output rate_sel,
        output enable,
        input clk_out
    );
endinterface

// ==== core/mxb_clk_div.sv ====
`timescale 1ns/1ps
// ==========================================================
// Clock output divider: f/2, f/4 or f/8 of the system clock, each with equal high and low time
module mxb_clk_div (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // Generator link
    mxb_clk_if.gen clk_link
);

    logic [2:0] div_reg;
    logic [2:0] div_next;
    logic clk_out_reg;
    logic clk_out_next;

    // ======================================================
    // Free running divider, stopped while disabled
    always_comb begin
        div_next = clk_link.enable ? div_reg + 3'h1 : mxb_pkg::RST_DIV;
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_reg <= mxb_pkg::RST_DIV;
        end else begin
            div_reg <= div_next;
        end
    end

    // ======================================================
    // Rate select; each divider bit toggles evenly
    always_comb begin
        unique case (clk_link.rate_sel)
            mxb_pkg::CLK_RATE_HALF: clk_out_next = div_next[1];
            mxb_pkg::CLK_RATE_QUARTER: clk_out_next = div_next[2];
            default: clk_out_next = div_next[0];
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            clk_out_reg <= 1'b0;
        end else begin
            clk_out_reg <= clk_out_next;
        end
    end

    assign clk_link.clk_out = clk_out_reg;

endmodule

// ==== core/mxb_bus_top.sv ====
`timescale 1ns/1ps
// What this block does
// - Address phase drives all sixteen address bits on the shared lines.
// - Data phase moves 8 or 16 bits by configured bus width.
// - Address-valid strobe is active low, only for external accesses.
// - Address-valid stays low whole cycle, rises when cycle completes.
// - Address-latch pulse is active high, only in external cycles.
// - Address-latch pulse marks start of every external bus cycle.
// - Latch pulse, valid strobe and port bit share one pin.
// - Each shared byte also serves a port byte and programming bus byte.
// - Clock output runs at half, quarter or eighth of the system clock rate.
// - Clock output has equal high and low time at every rate.
// - Clock output pin shared with port bit and programming-active flag.
module mxb_bus_top #(
    parameter int unsigned ADDR_CYCLES = mxb_pkg::ADDR_CYCLES,
    parameter int unsigned LATCH_CYCLES = mxb_pkg::LATCH_PULSE_CYCLES,
    parameter int unsigned DATA_CYCLES = mxb_pkg::DATA_CYCLES
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // Configuration
    input wire logic bus_enable_i,
    input wire logic bus_width16_i,
    input wire logic strobe_mode_i,
    input wire logic prog_mode_i,
    input wire logic clock_output_pin_enable_i,
    input wire logic [1:0] clock_output_pin_rate_i,
    // Access request
    input wire logic req_valid_i,
    input wire logic req_ext_i,
    input wire logic req_write_i,
    input wire logic [15:0] req_addr_i,
    input wire logic [15:0] req_wdata_i,
    output logic req_ready_o,
    // Access answer
    output logic rsp_valid_o,
    output logic [15:0] rsp_rdata_o,
    // Port and programming side
    input wire logic [7:0] port3_byte_out_i,
    input wire logic [7:0] port3_byte_oe_i,
    input wire logic [7:0] port4_byte_out_i,
    input wire logic [7:0] port4_byte_oe_i,
    input wire logic port5_bit0_out_i,
    input wire logic port5_bit0_oe_i,
    input wire logic port2_bit7_out_i,
    input wire logic port2_bit7_oe_i,
    input wire logic [7:0] prog_bus_low_out_i,
    input wire logic [7:0] prog_bus_high_out_i,
    input wire logic prog_bus_oe_i,
    input wire logic prog_active_n_i,
    output logic [7:0] port3_byte_in_o,
    output logic [7:0] port4_byte_in_o,
    output logic port5_bit0_in_o,
    output logic port2_bit7_in_o,
    output logic [7:0] prog_bus_low_in_o,
    output logic [7:0] prog_bus_high_in_o,
    // Shared address/data pins
    input wire logic [15:0] muxed_addr_data_i,
    output logic [15:0] muxed_addr_data_o,
    output logic [15:0] muxed_addr_data_oe_o,
    // Strobe pin
    input wire logic strobe_pin_i,
    output logic strobe_pin_o,
    output logic strobe_pin_oe_o,
    // Read and write strobes
    output logic rd_strobe_n_o,
    output logic wr_strobe_n_o,
    // Clock output pin
    input wire logic clock_output_pin_i,
    output logic clock_output_pin_o,
    output logic clock_output_pin_oe_o
);

    localparam int unsigned CNT_W = 4;

    mxb_pkg::mxb_state_t state_reg;
    mxb_pkg::mxb_state_t state_next;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic [15:0] addr_reg;
    logic [15:0] wdata_reg;
    logic write_reg;
    logic wide_reg;
    logic start;
    logic addr_last;
    logic data_last;
    logic ale_reg;
    logic addr_valid_n_reg;
    logic rd_n_reg;
    logic wr_n_reg;
    logic [15:0] ad_out_reg;
    logic [1:0] ad_oe_reg;
    logic [15:0] ad_out_next;
    logic [1:0] ad_oe_next;
    logic rsp_valid_reg;
    logic [15:0] rsp_rdata_reg;

    mxb_clk_if clk_link();

    // ======================================================
    // Request handshake
    assign req_ready_o = (state_reg == mxb_pkg::MXB_IDLE);
    assign start = req_ready_o && req_valid_i && req_ext_i;
    assign addr_last = (cnt_reg == CNT_W'(ADDR_CYCLES - 1));
    assign data_last = (cnt_reg == CNT_W'(DATA_CYCLES - 1));

    // ======================================================
    // Sequencer next state
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        unique case (state_reg)
            mxb_pkg::MXB_IDLE: begin
                if (start) begin
                    state_next = mxb_pkg::MXB_ADDR;
                    cnt_next = '0;
                end
            end
            mxb_pkg::MXB_ADDR: begin
                if (addr_last) begin
                    state_next = mxb_pkg::MXB_DATA;
                    cnt_next = '0;
                end else begin
                    cnt_next = cnt_reg + CNT_W'(1);
                end
            end
            mxb_pkg::MXB_DATA: begin
                if (data_last) begin
                    state_next = mxb_pkg::MXB_IDLE;
                    cnt_next = '0;
                end else begin
                    cnt_next = cnt_reg + CNT_W'(1);
                end
            end
            default: begin
                state_next = mxb_pkg::MXB_IDLE;
                cnt_next = '0;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg <= mxb_pkg::MXB_IDLE;
            cnt_reg <= '0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
        end
    end

    // ======================================================
    // Request capture
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            addr_reg <= mxb_pkg::RST_WORD;
            wdata_reg <= mxb_pkg::RST_WORD;
            write_reg <= 1'b0;
            wide_reg <= 1'b0;
        end else if (start) begin
            addr_reg <= req_addr_i;
            wdata_reg <= req_wdata_i;
            write_reg <= req_write_i;
            wide_reg <= bus_width16_i;
        end
    end

    // ======================================================
    // Address/data drive for the coming cycle
    always_comb begin
        ad_out_next = mxb_pkg::RST_WORD;
        ad_oe_next = 2'h0;
        unique case (state_next)
            mxb_pkg::MXB_ADDR: begin
                ad_out_next = start ? req_addr_i : addr_reg;
                ad_oe_next = 2'h3;
            end
            mxb_pkg::MXB_DATA: begin
                if (write_reg) begin
                    ad_out_next = wide_reg ? wdata_reg : {addr_reg[15:8], wdata_reg[7:0]};
                    ad_oe_next = 2'h3;
                end else begin
                    ad_out_next = {addr_reg[15:8], 8'h00};
                    ad_oe_next = wide_reg ? 2'h0 : 2'h2;
                end
            end
            default: begin
                ad_out_next = mxb_pkg::RST_WORD;
                ad_oe_next = 2'h0;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ad_out_reg <= mxb_pkg::RST_WORD;
            ad_oe_reg <= 2'h0;
        end else begin
            ad_out_reg <= ad_out_next;
            ad_oe_reg <= ad_oe_next;
        end
    end

    // ======================================================
    // Bus strobes
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ale_reg <= 1'b0;
            addr_valid_n_reg <= 1'b1;
            rd_n_reg <= 1'b1;
            wr_n_reg <= 1'b1;
        end else begin
            ale_reg <= (state_next == mxb_pkg::MXB_ADDR) && (cnt_next < CNT_W'(LATCH_CYCLES));
            addr_valid_n_reg <= (state_next == mxb_pkg::MXB_IDLE);
            rd_n_reg <= !((state_next == mxb_pkg::MXB_DATA) && !write_reg);
            wr_n_reg <= !((state_next == mxb_pkg::MXB_DATA) && write_reg);
        end
    end

    // ======================================================
    // Read data capture and completion pulse
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rsp_valid_reg <= 1'b0;
            rsp_rdata_reg <= mxb_pkg::RST_WORD;
        end else begin
            rsp_valid_reg <= (state_reg == mxb_pkg::MXB_DATA) && data_last;
            if ((state_reg == mxb_pkg::MXB_DATA) && data_last && !write_reg) begin
                rsp_rdata_reg <= wide_reg ? muxed_addr_data_i : {8'h00, muxed_addr_data_i[7:0]};
            end
        end
    end

    assign rsp_valid_o = rsp_valid_reg;
    assign rsp_rdata_o = rsp_rdata_reg;
    assign rd_strobe_n_o = rd_n_reg;
    assign wr_strobe_n_o = wr_n_reg;

    // ======================================================
    // Clock output generator
    assign clk_link.rate_sel = clock_output_pin_rate_i;
    assign clk_link.enable = clock_output_pin_enable_i;

    mxb_clk_div u_clk_div (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .clk_link(clk_link)
    );

    // ======================================================
    // Shared address/data pins
    always_comb begin
        if (prog_mode_i) begin
            muxed_addr_data_o = {prog_bus_high_out_i, prog_bus_low_out_i};
            muxed_addr_data_oe_o = {16{prog_bus_oe_i}};
        end else if (bus_enable_i) begin
            muxed_addr_data_o = ad_out_reg;
            muxed_addr_data_oe_o = {{8{ad_oe_reg[1]}}, {8{ad_oe_reg[0]}}};
        end else begin
            muxed_addr_data_o = {port4_byte_out_i, port3_byte_out_i};
            muxed_addr_data_oe_o = {port4_byte_oe_i, port3_byte_oe_i};
        end
    end

    assign port3_byte_in_o = muxed_addr_data_i[7:0];
    assign port4_byte_in_o = muxed_addr_data_i[15:8];
    assign prog_bus_low_in_o = muxed_addr_data_i[7:0];
    assign prog_bus_high_in_o = muxed_addr_data_i[15:8];

    // ======================================================
    // Strobe pin: one function drives it at a time
    always_comb begin
        if (bus_enable_i && !prog_mode_i) begin
            strobe_pin_o = (strobe_mode_i == mxb_pkg::STROBE_IS_VALID) ? addr_valid_n_reg : ale_reg;
            strobe_pin_oe_o = 1'b1;
        end else begin
            strobe_pin_o = port5_bit0_out_i;
            strobe_pin_oe_o = port5_bit0_oe_i;
        end
    end

    assign port5_bit0_in_o = strobe_pin_i;

    // ======================================================
    // Clock output pin
    always_comb begin
        if (prog_mode_i) begin
            clock_output_pin_o = prog_active_n_i;
            clock_output_pin_oe_o = 1'b1;
        end else if (clock_output_pin_enable_i) begin
            clock_output_pin_o = clk_link.clk_out;
            clock_output_pin_oe_o = 1'b1;
        end else begin
            clock_output_pin_o = port2_bit7_out_i;
            clock_output_pin_oe_o = port2_bit7_oe_i;
        end
    end

    assign port2_bit7_in_o = clock_output_pin_i;

endmodule

// ==== dv/mxb_bus_properties.sv ====
`timescale 1ns/1ps
// ====
// Bus strobe and clock output checks
module mxb_bus_properties #(
    parameter int unsigned ADDR_CYCLES = 2,
    parameter int unsigned LATCH_CYCLES = 1,
    parameter int unsigned DATA_CYCLES = 3
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // Configuration
    input wire logic bus_enable_i,
    input wire logic bus_width16_i,
    input wire logic strobe_mode_i,
    input wire logic prog_mode_i,
    input wire logic clock_output_pin_enable_i,
    input wire logic [1:0] clock_output_pin_rate_i,
    // Request and answer
    input wire logic req_valid_i,
    input wire logic req_ext_i,
    input wire logic req_write_i,
    input wire logic [15:0] req_addr_i,
    input wire logic [15:0] req_wdata_i,
    input wire logic req_ready_o,
    input wire logic rsp_valid_o,
    // Pins
    input wire logic [15:0] muxed_addr_data_o,
    input wire logic [15:0] muxed_addr_data_oe_o,
    input wire logic strobe_pin_o,
    input wire logic strobe_pin_oe_o,
    input wire logic clock_output_pin_o
);
    localparam int RSP_LAT = ADDR_CYCLES + DATA_CYCLES + 1;
    logic take;
    assign take = req_valid_i && req_ready_o && req_ext_i && bus_enable_i && !prog_mode_i;
    default clocking @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_n_i);
    sequence s_latch_pulse;
        strobe_pin_o ##1 !strobe_pin_o;
    endsequence
    sequence s_valid_window;
        !strobe_pin_o [*5] ##1 strobe_pin_o;
    endsequence
    a_addr_drive:
    assert property (take |-> ##2 muxed_addr_data_oe_o == 16'hFFFF && muxed_addr_data_o == $past(req_addr_i, 2))
        else $error("Address not driven on shared lines");
    a_write_data:
    assert property (take && req_write_i && bus_width16_i |-> ##4 muxed_addr_data_o == $past(req_wdata_i, 4))
        else $error("Write data not driven in data phase");
    a_read_free16:
    assert property (take && !req_write_i && bus_width16_i |-> ##4 muxed_addr_data_oe_o == 16'h0000)
        else $error("Shared lines not released for word read");
    a_read_free8:
    assert property (take && !req_write_i && !bus_width16_i |-> ##4 muxed_addr_data_oe_o == 16'hFF00)
        else $error("Low lines not released for byte read");
    a_latch_pulse:
    assert property (take && !strobe_mode_i |-> ##1 s_latch_pulse)
        else $error("Latch pulse missing at cycle start");
    a_valid_window:
    assert property (take && strobe_mode_i |-> ##1 s_valid_window)
        else $error("Address valid strobe window wrong");
    a_rsp_latency:
    assert property (take |-> ##RSP_LAT rsp_valid_o)
        else $error("Cycle completion late");
    a_strobe_idle:
    assert property ((bus_enable_i && !prog_mode_i && req_ready_o && !(req_valid_i && req_ext_i)) [*3]
        |=> strobe_pin_o == strobe_mode_i)
        else $error("Strobe active without external cycle");
    a_strobe_owned:
    assert property (bus_enable_i && !prog_mode_i |-> strobe_pin_oe_o)
        else $error("Strobe pin not driven in bus mode");
    a_clk_full:
    assert property (disable iff (!rst_n_i || !clock_output_pin_enable_i || prog_mode_i)
        clock_output_pin_rate_i == mxb_pkg::CLK_RATE_FULL && $rose(clock_output_pin_o)
        |=> !clock_output_pin_o ##1 clock_output_pin_o)
        else $error("Full rate clock output wrong");
    a_clk_half:
    assert property (disable iff (!rst_n_i || !clock_output_pin_enable_i || prog_mode_i)
        clock_output_pin_rate_i == mxb_pkg::CLK_RATE_HALF && $rose(clock_output_pin_o)
        |-> clock_output_pin_o [*2] ##1 !clock_output_pin_o [*2] ##1 clock_output_pin_o)
        else $error("Half rate clock output wrong");
    a_clk_quarter:
    assert property (disable iff (!rst_n_i || !clock_output_pin_enable_i || prog_mode_i)
        clock_output_pin_rate_i == mxb_pkg::CLK_RATE_QUARTER && $rose(clock_output_pin_o)
        |-> clock_output_pin_o [*4] ##1 !clock_output_pin_o [*4] ##1 clock_output_pin_o)
        else $error("Quarter rate clock output wrong");
endmodule

// ==== dv/mxb_mem_model.sv ====
`timescale 1ns/1ps
// ====
// External address latch and memory
module mxb_mem_model (
    // Clock
    input wire logic sys_clk_i,
    // Bus pins
    input wire logic [15:0] ad_pin_i,
    input wire logic strobe_pin_i,
    input wire logic rd_n_i,
    input wire logic wr_n_i,
    // Board setup
    input wire logic strobe_mode_i,
    input wire logic width16_i,
    input wire logic slow_i,
    // Memory drive
    output logic [15:0] mem_d_o,
    output logic [15:0] mem_oe_o,
    output logic [15:0] lat_addr_o
);
    logic [15:0] mem [logic [15:0]];
    logic prev_strobe = 1'b1;
    logic [1:0] rd_cnt = 2'h0;
    always @(posedge sys_clk_i) begin
        prev_strobe <= strobe_pin_i;
        if (strobe_mode_i ? (!strobe_pin_i && prev_strobe) : strobe_pin_i) begin
            lat_addr_o <= ad_pin_i;
        end
        if (!wr_n_i) begin
            mem[lat_addr_o] = width16_i ? ad_pin_i : {8'h00, ad_pin_i[7:0]};
        end
        if (mem.exists(lat_addr_o)) begin
            mem_d_o <= mem[lat_addr_o];
        end
        rd_cnt <= rd_n_i ? 2'h0 : (rd_cnt == 2'h3 ? rd_cnt : rd_cnt + 2'h1);
    end
    assign mem_oe_o = (!rd_n_i && rd_cnt >= {1'b0, slow_i}) ? (width16_i ? 16'hFFFF : 16'h00FF) : 16'h0000;
endmodule

// ==== dv/tb_top.sv ====
`timescale 1ns/1ps
// ====
// Bench for the multiplexed bus block
module tb_top;
    typedef struct packed {logic w16; logic sm; logic [15:0] a; logic [15:0] d; logic [15:0] e;} mxb_row_t;
    localparam mxb_row_t ROWS [4] = '{'{1'b1, 1'b0, 16'h1234, 16'hA5C3, 16'hA5C3},
        '{1'b0, 1'b1, 16'h00F0, 16'h5A7E, 16'h007E}, '{1'b1, 1'b1, 16'hFFFF, 16'h0001, 16'h0001},
        '{1'b0, 1'b0, 16'h8001, 16'hFFFF, 16'h00FF}};
    localparam logic [15:0] RSP_N = 16'(mxb_pkg::ADDR_CYCLES + mxb_pkg::DATA_CYCLES + 1);
    logic sys_clk_i = 1'b0, rst_n_i = 1'b0, slow = 1'b0;
    logic bus_enable_i = 1'b1, bus_width16_i = 1'b1, strobe_mode_i = 1'b0, prog_mode_i = 1'b0;
    logic clock_output_pin_enable_i = 1'b0, req_valid_i = 1'b0, req_ext_i = 1'b1, req_write_i = 1'b0;
    logic [1:0] clock_output_pin_rate_i = 2'h0;
    logic [15:0] req_addr_i = 16'h0000, req_wdata_i = 16'h0000, pt_o = 16'h0000, pt_oe = 16'h0000;
    logic [15:0] pg_o = 16'h0000, noise = 16'h5A5A;
    logic port5_bit0_out_i = 1'b0, port5_bit0_oe_i = 1'b0, port2_bit7_out_i = 1'b1, port2_bit7_oe_i = 1'b1;
    logic prog_bus_oe_i = 1'b0, prog_active_n_i = 1'b0;
    wire logic [7:0] port3_byte_out_i = pt_o[7:0], port3_byte_oe_i = pt_oe[7:0];
    wire logic [7:0] port4_byte_out_i = pt_o[15:8], port4_byte_oe_i = pt_oe[15:8];
    wire logic [7:0] prog_bus_low_out_i = pg_o[7:0], prog_bus_high_out_i = pg_o[15:8];
    logic req_ready_o, rsp_valid_o, strobe_pin_o, strobe_pin_oe_o, rd_strobe_n_o, wr_strobe_n_o;
    logic port5_bit0_in_o, port2_bit7_in_o, clock_output_pin_o, clock_output_pin_oe_o;
    logic [7:0] port3_byte_in_o, port4_byte_in_o, prog_bus_low_in_o, prog_bus_high_in_o;
    logic [15:0] rsp_rdata_o, muxed_addr_data_o, muxed_addr_data_oe_o, mem_d, mem_oe, lat;
    wire logic [15:0] muxed_addr_data_i = (muxed_addr_data_oe_o & muxed_addr_data_o)
        | (~muxed_addr_data_oe_o & mem_oe & mem_d) | (~muxed_addr_data_oe_o & ~mem_oe & noise);
    wire logic strobe_pin_i = strobe_pin_oe_o ? strobe_pin_o : noise[0];
    wire logic clock_output_pin_i = clock_output_pin_oe_o ? clock_output_pin_o : noise[1];
    int n_mismatch = 0, n_checks = 0, h, l, hp;
    mxb_bus_top dut_u (.*);
    mxb_mem_model mem_u (.sys_clk_i(sys_clk_i), .ad_pin_i(muxed_addr_data_i), .strobe_pin_i(strobe_pin_i),
        .rd_n_i(rd_strobe_n_o), .wr_n_i(wr_strobe_n_o), .strobe_mode_i(strobe_mode_i),
        .width16_i(bus_width16_i), .slow_i(slow), .mem_d_o(mem_d), .mem_oe_o(mem_oe), .lat_addr_o(lat));
    initial begin
        forever #2.5 sys_clk_i = ~sys_clk_i;
    end
    always @(posedge sys_clk_i) noise <= ~noise;
    // ====
    // Compare, wait and bus tasks
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk1(input string nm, input logic e, input logic g);
        n_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic complete_run;
        if (n_mismatch == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic step(inout int c);
        @(negedge sys_clk_i);
        c++;
        if (c > 40) begin
            n_mismatch++;
            complete_run();
        end
    endtask
    task automatic req(input logic x, input logic w, input logic [15:0] a, input logic [15:0] d);
        int c;
        c = 0;
        req_valid_i = 1'b1;
        req_ext_i = x;
        req_write_i = w;
        req_addr_i = a;
        req_wdata_i = d;
        while (req_ready_o !== 1'b1) step(c);
        @(negedge sys_clk_i);
    endtask
    task automatic access(input logic w, input logic [15:0] a, input logic [15:0] d);
        int c;
        c = 1;
        req(1'b1, w, a, d);
        req_valid_i = 1'b0;
        while (rsp_valid_o !== 1'b1) step(c);
        chk("rsp_latency", RSP_N, c[15:0]);
    endtask
    // ====
    // Main sequence
    initial begin
        repeat (6) @(negedge sys_clk_i);
        rst_n_i = 1'b1;
        foreach (ROWS[k]) begin
            @(negedge sys_clk_i);
            bus_width16_i = ROWS[k].w16;
            strobe_mode_i = ROWS[k].sm;
            slow = k[0];
            access(1'b1, ROWS[k].a, ROWS[k].d);
            chk("latched_addr", ROWS[k].a, lat);
            access(1'b0, ROWS[k].a, 16'h0000);
            chk("read_data", ROWS[k].e, rsp_rdata_o);
        end
        req(1'b0, 1'b0, 16'h0F0F, 16'h0000);
        req_valid_i = 1'b0;
        repeat (8) begin
            @(negedge sys_clk_i);
            chk1("int_rsp", 1'b0, rsp_valid_o);
            chk1("int_strobe", strobe_mode_i, strobe_pin_o);
        end
        bus_width16_i = 1'b1;
        req(1'b1, 1'b1, 16'h4C2D, 16'h7E81);
        access(1'b0, 16'h4C2D, 16'h0000);
        chk("b2b_read", 16'h7E81, rsp_rdata_o);
        bus_enable_i = 1'b0;
        pt_o = 16'hC35A;
        pt_oe = 16'hF00F;
        port5_bit0_out_i = 1'b1;
        port5_bit0_oe_i = 1'b1;
        #1;
        chk("port_out", pt_o, muxed_addr_data_o);
        chk("port_oe", pt_oe, muxed_addr_data_oe_o);
        chk("port_in", (pt_o & pt_oe) | (~pt_oe & noise), {port4_byte_in_o, port3_byte_in_o});
        chk1("port5_pin", 1'b1, strobe_pin_o);
        chk1("port5_in", 1'b1, port5_bit0_in_o);
        prog_mode_i = 1'b1;
        pg_o = 16'h9E61;
        prog_bus_oe_i = 1'b1;
        #1;
        chk("prog_bus", pg_o, muxed_addr_data_o);
        chk("prog_in", pg_o, {prog_bus_high_in_o, prog_bus_low_in_o});
        chk1("prog_active", 1'b0, clock_output_pin_o);
        @(negedge sys_clk_i);
        prog_mode_i = 1'b0;
        prog_bus_oe_i = 1'b0;
        bus_enable_i = 1'b1;
        #1;
        chk1("port2_pin", 1'b1, clock_output_pin_o);
        chk1("port2_in", 1'b1, port2_bit7_in_o);
        chk1("clk_pin_oe", 1'b1, clock_output_pin_oe_o);
        for (int r = 0; r < 4; r++) begin
            clock_output_pin_rate_i = r[1:0];
            clock_output_pin_enable_i = 1'b1;
            hp = (r == 1) ? 2 : (r == 2) ? 4 : 1;
            repeat (9) @(negedge sys_clk_i);
            l = 0;
            while (clock_output_pin_o !== 1'b1) step(l);
            h = 0;
            l = 0;
            while (clock_output_pin_o === 1'b1) step(h);
            while (clock_output_pin_o !== 1'b1) step(l);
            chk("clk_high", hp[15:0], h[15:0]);
            chk("clk_low", hp[15:0], l[15:0]);
            clock_output_pin_enable_i = 1'b0;
            @(negedge sys_clk_i);
        end
        strobe_mode_i = 1'b1;
        req(1'b1, 1'b0, 16'h1234, 16'h0000);
        req_valid_i = 1'b0;
        repeat (4) @(negedge sys_clk_i);
        rst_n_i = 1'b0;
        #1;
        chk("rst_oe", 16'h0000, muxed_addr_data_oe_o);
        chk1("rst_valid", 1'b1, strobe_pin_o);
        chk1("rst_rd", 1'b1, rd_strobe_n_o);
        chk1("rst_wr", 1'b1, wr_strobe_n_o);
        @(negedge sys_clk_i);
        rst_n_i = 1'b1;
        access(1'b0, 16'h1234, 16'h0000);
        chk("rst_read", 16'hA5C3, rsp_rdata_o);
        complete_run();
    end
endmodule
bind mxb_bus_top mxb_bus_properties #(.ADDR_CYCLES(ADDR_CYCLES), .LATCH_CYCLES(LATCH_CYCLES),
    .DATA_CYCLES(DATA_CYCLES)) chk_u (.*);
